// *** src/irc_host.sv ***
// rate converter controller: AXI4-Lite registers, safe rate change sequence, enable forwarding
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module irc_host #(
	parameter int SETTLE_CYCLES = irc_pkg::SETTLE_CYC,
	parameter int SYS1_HZ       = 48000,
	parameter int SYS2_HZ       = 16000,
	parameter int SYS3_HZ       = 8000,
	parameter int ASY1_HZ       = 44100,
	parameter int ASY2_HZ       = 22050
) (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	// axi4-lite write
	input  wire logic [31:0] s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	// axi4-lite read
	input  wire logic [31:0] s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// system audio clock state and source selectors
	input  wire logic        system_audio_clock_en_i,
	output logic [31:0]      input_source_select_o,
	// device side
	irc_if.host              bus
);
	typedef enum logic [2:0] {H_IDLE, H_CLEAR, H_WAIT, H_WR_HI, H_WR_LO, H_RESTORE} irc_hst_t;

	typedef struct packed {
		irc_hst_t    st;
		logic [15:0] cnt;
		logic [3:0]  hi_code;
		logic [3:0]  lo_code;
		logic [3:0]  new_hi;
		logic [3:0]  new_lo;
		logic [3:0]  path_en;
		logic [3:0]  sent_en;
		logic [31:0] src;
		logic [3:0]  hold;
		logic [31:0] src_out;
		logic        err;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        reg_wr;
		logic [11:0] reg_idx;
		logic [15:0] reg_wdata;
	} irc_host_st_t;

	irc_host_st_t s;
	irc_host_st_t next_s;
	logic [3:0]   want;
	logic [3:0]   wh;
	logic [3:0]   wl;

	// rate in hz for a code
	function automatic logic [irc_pkg::HZ_W-1:0] hz(input logic [3:0] c);
		case (c)
			irc_pkg::CODE_SYS1: return irc_pkg::HZ_W'(SYS1_HZ);
			irc_pkg::CODE_SYS2: return irc_pkg::HZ_W'(SYS2_HZ);
			irc_pkg::CODE_SYS3: return irc_pkg::HZ_W'(SYS3_HZ);
			irc_pkg::CODE_ASY1: return irc_pkg::HZ_W'(ASY1_HZ);
			irc_pkg::CODE_ASY2: return irc_pkg::HZ_W'(ASY2_HZ);
			default:            return '0;
		endcase
	endfunction

	// rate lies in the supported range
	function automatic logic in_range(input logic [3:0] c);
		return (hz(c) >= irc_pkg::RATE_MIN_HZ) && (hz(c) <= irc_pkg::RATE_MAX_HZ);
	endfunction

	// ----------
	// bus slave, sequence and forwarding
	// ----------
	always_comb begin
		next_s         = s;
		want           = s.path_en & {4{system_audio_clock_en_i}};
		wh             = s_axi_wdata_i[3:0];
		wl             = s_axi_wdata_i[7:4];
		next_s.reg_wr  = 1'b0;
		next_s.awready = s_axi_awvalid_i && s_axi_wvalid_i && !s.awready && !s.bvalid && (s.st == H_IDLE);
		next_s.wready  = next_s.awready;
		next_s.arready = s_axi_arvalid_i && !s.arready && !s.rvalid;
		// write response follows both handshakes by one cycle
		if (s.bvalid && s_axi_bready_i) begin
			next_s.bvalid = 1'b0;
		end
		if (s.awready) begin
			next_s.bvalid = 1'b1;
			next_s.bresp  = irc_pkg::RESP_OKAY;
			case (s_axi_awaddr_i)
				irc_pkg::A_RATES: begin
					if (!s_axi_wstrb_i[0]) begin
						next_s.bresp = irc_pkg::RESP_OKAY;
					end else if (!(irc_pkg::code_ok(wh) && irc_pkg::code_ok(wl) &&
						(wh[irc_pkg::ASYNC_BIT] == wl[irc_pkg::ASYNC_BIT]) &&
						(hz(wh) >= hz(wl)) && in_range(wh) && in_range(wl))) begin
						next_s.err = 1'b1;
					end else if ((wh != s.hi_code) || (wl != s.lo_code)) begin
						next_s.new_hi = wh;
						next_s.new_lo = wl;
						next_s.hold   = {{2{wh != s.hi_code}}, {2{wl != s.lo_code}}};
						next_s.st     = H_CLEAR;
					end
				end
				irc_pkg::A_PATH: begin
					if (s_axi_wstrb_i[0]) begin
						next_s.path_en = s_axi_wdata_i[3:0];
					end
				end
				irc_pkg::A_SRC: begin
					for (int i = 0; i < 4; i++) begin
						if (s_axi_wstrb_i[i]) begin
							next_s.src[8*i +: 8] = s_axi_wdata_i[8*i +: 8];
						end
					end
				end
				irc_pkg::A_STAT: begin
					if (s_axi_wstrb_i[0] && s_axi_wdata_i[irc_pkg::ST_ERR_BIT]) begin
						next_s.err = 1'b0;
					end
				end
				default: begin
					next_s.bresp = irc_pkg::RESP_SLVERR;
				end
			endcase
		end
		// read data one cycle after the address handshake
		if (s.rvalid && s_axi_rready_i) begin
			next_s.rvalid = 1'b0;
		end
		if (s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = irc_pkg::RESP_OKAY;
			next_s.rdata  = 32'h0000_0000;
			case (s_axi_araddr_i)
				irc_pkg::A_RATES: next_s.rdata[7:0] = {s.lo_code, s.hi_code};
				irc_pkg::A_PATH:  next_s.rdata[3:0] = s.path_en;
				irc_pkg::A_SRC:   next_s.rdata      = s.src;
				irc_pkg::A_STAT: begin
					next_s.rdata[3:0]                  = bus.path_active;
					next_s.rdata[irc_pkg::ST_UCLK_BIT] = bus.underclock;
					next_s.rdata[irc_pkg::ST_BUSY_BIT] = (s.st != H_IDLE);
					next_s.rdata[irc_pkg::ST_ERR_BIT]  = s.err;
				end
				default:          next_s.rresp      = irc_pkg::RESP_SLVERR;
			endcase
		end
		// rate change sequence and enable forwarding
		case (s.st)
			H_IDLE: begin
				if (want != s.sent_en) begin
					next_s.reg_wr    = 1'b1;
					next_s.reg_idx   = irc_pkg::PATH_EN_IDX;
					next_s.reg_wdata = irc_pkg::en_word(want);
					next_s.sent_en   = want;
				end
			end
			H_CLEAR: begin
				next_s.cnt = 16'(SETTLE_CYCLES - 1);
				next_s.st  = H_WAIT;
			end
			H_WAIT: begin
				if (s.cnt == 16'h0000) begin
					next_s.st = H_WR_HI;
				end else begin
					next_s.cnt = s.cnt - 16'h0001;
				end
			end
			H_WR_HI: begin
				next_s.reg_wr    = 1'b1;
				next_s.reg_idx   = irc_pkg::HI_RATE_IDX;
				next_s.reg_wdata = irc_pkg::rate_word(s.new_hi);
				next_s.hi_code   = s.new_hi;
				next_s.st        = H_WR_LO;
			end
			H_WR_LO: begin
				next_s.reg_wr    = 1'b1;
				next_s.reg_idx   = irc_pkg::LO_RATE_IDX;
				next_s.reg_wdata = irc_pkg::rate_word(s.new_lo);
				next_s.lo_code   = s.new_lo;
				next_s.st        = H_RESTORE;
			end
			H_RESTORE: begin
				next_s.hold = 4'h0;
				next_s.st   = H_IDLE;
			end
			default: begin
				next_s.st = H_IDLE;
			end
		endcase
		// selectors held at zero while clearing or without system clock
		for (int i = 0; i < 4; i++) begin
			next_s.src_out[8*i +: 8] = (system_audio_clock_en_i && !next_s.hold[i]) ?
				next_s.src[8*i +: 8] : 8'h00;
		end
	end

	// state register
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			s    <= '0;
			s.st <= H_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from state
	assign s_axi_awready_o       = s.awready;
	assign s_axi_wready_o        = s.wready;
	assign s_axi_bvalid_o        = s.bvalid;
	assign s_axi_bresp_o         = s.bresp;
	assign s_axi_arready_o       = s.arready;
	assign s_axi_rvalid_o        = s.rvalid;
	assign s_axi_rdata_o         = s.rdata;
	assign s_axi_rresp_o         = s.rresp;
	assign input_source_select_o = s.src_out;
	assign bus.reg_wr            = s.reg_wr;
	assign bus.reg_idx           = s.reg_idx;
	assign bus.reg_wdata         = s.reg_wdata;
endmodule
`default_nettype wire

// *** src/irc_pkg.sv ***
// shared constants, register layout and helpers for the isochronous rate converter
package irc_pkg;
	// ----------
	// device register indices and fields
	// ----------
	localparam logic [11:0] HI_RATE_IDX = 12'h0ef9;
	localparam logic [11:0] LO_RATE_IDX = 12'h0efa;
	localparam logic [11:0] PATH_EN_IDX = 12'h0efb;
	localparam int          REG_W       = 16;
	localparam int          RATE_LSB    = 11;
	localparam int          RATE_W      = 4;
	localparam int          ASYNC_BIT   = 3;
	localparam logic [3:0]  RATE_RST    = 4'h0;
	localparam int          UP1_BIT     = 15;
	localparam int          UP2_BIT     = 14;
	localparam int          DN1_BIT     = 9;
	localparam int          DN2_BIT     = 8;
	// rate codes
	localparam logic [3:0]  CODE_SYS1   = 4'h0;
	localparam logic [3:0]  CODE_SYS2   = 4'h1;
	localparam logic [3:0]  CODE_SYS3   = 4'h2;
	localparam logic [3:0]  CODE_ASY1   = 4'h8;
	localparam logic [3:0]  CODE_ASY2   = 4'h9;
	// ----------
	// paths, samples and clock budget
	// ----------
	localparam int          NPATH       = 4;
	localparam int          SMP_W       = 24;
	localparam int          BUD_W       = 16;
	localparam logic [15:0] PATH_COST   = 16'h0010;
	// ----------
	// timing and rate limits
	// ----------
	localparam int          CLK_MHZ     = 200;
	localparam int          SETTLE_US   = 125;
	localparam int          SETTLE_CYC  = SETTLE_US * CLK_MHZ;
	localparam int          HZ_W        = 18;
	localparam logic [17:0] RATE_MIN_HZ = 18'h0_1f40;
	localparam logic [17:0] RATE_MAX_HZ = 18'h2_ee00;
	// ----------
	// controller register map (byte offsets) and status bits
	// ----------
	localparam logic [31:0] A_RATES     = 32'h0000_0000;
	localparam logic [31:0] A_PATH      = 32'h0000_0004;
	localparam logic [31:0] A_SRC       = 32'h0000_0008;
	localparam logic [31:0] A_STAT      = 32'h0000_000c;
	localparam int          ST_UCLK_BIT = 4;
	localparam int          ST_BUSY_BIT = 5;
	localparam int          ST_ERR_BIT  = 6;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// code names a defined rate
	function automatic logic code_ok(input logic [3:0] c);
		return (c == CODE_SYS1) || (c == CODE_SYS2) || (c == CODE_SYS3) ||
			(c == CODE_ASY1) || (c == CODE_ASY2);
	endfunction

	// rate code placed in its register field
	function automatic logic [15:0] rate_word(input logic [3:0] c);
		logic [15:0] w;
		w = 16'h0000;
		w[RATE_LSB +: RATE_W] = c;
		return w;
	endfunction

	// path vector (up1, up2, dn1, dn2) to enable register word
	function automatic logic [15:0] en_word(input logic [3:0] p);
		logic [15:0] w;
		w = 16'h0000;
		w[UP1_BIT] = p[0];
		w[UP2_BIT] = p[1];
		w[DN1_BIT] = p[2];
		w[DN2_BIT] = p[3];
		return w;
	endfunction

	// enable register word to path vector
	function automatic logic [3:0] en_bits(input logic [15:0] w);
		return {w[DN2_BIT], w[DN1_BIT], w[UP2_BIT], w[UP1_BIT]};
	endfunction
endpackage

// *** src/irc_if.sv ***
// register and status link between rate converter controller and device
`timescale 1ns/1ps
`default_nettype none
interface irc_if;
	logic                      reg_wr;
	logic [11:0]               reg_idx;
	logic [15:0]               reg_wdata;
	logic [irc_pkg::NPATH-1:0] path_active;
	logic                      underclock;

	modport dev (
		input  reg_wr,
		input  reg_idx,
		input  reg_wdata,
		output path_active,
		output underclock
	);

	modport host (
		output reg_wr,
		output reg_idx,
		output reg_wdata,
		input  path_active,
		input  underclock
	);
endinterface
`default_nettype wire

// *** src/irc_path.sv ***
// one resampling path: holds the latest input sample, emits it on output strobes
`timescale 1ns/1ps
`default_nettype none
module irc_path (
	// clock and reset
	input  wire logic                      mclk_i,
	input  wire logic                      rstn_i,
	// control
	input  wire logic                      en_i,
	// input side
	input  wire logic                      in_stb_i,
	input  wire logic [irc_pkg::SMP_W-1:0] in_smp_i,
	// output side
	input  wire logic                      out_stb_i,
	output logic                           out_vld_o,
	output logic [irc_pkg::SMP_W-1:0]      out_smp_o
);
	typedef struct packed {
		logic [irc_pkg::SMP_W-1:0] held;
		logic                      vld;
		logic [irc_pkg::SMP_W-1:0] smp;
	} irc_path_st_t;

	irc_path_st_t s;
	irc_path_st_t next_s;

	// ----------
	// integer-ratio hold: repeats on interpolation, drops on decimation
	// ----------
	always_comb begin
		next_s     = s;
		next_s.vld = 1'b0;
		if (!en_i) begin
			next_s.held = '0; // idle path forgets its history
		end else begin
			if (in_stb_i) begin
				next_s.held = in_smp_i;
			end
			if (out_stb_i) begin
				next_s.vld = 1'b1;
				next_s.smp = in_stb_i ? in_smp_i : s.held;
			end
		end
	end

	// state register
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign out_vld_o = s.vld;
	assign out_smp_o = s.smp;
endmodule
`default_nettype wire

// *** src/irc_dev.sv ***
// rate converter device end: rate selectors, path enables, clock check, resampling paths
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - higher rate goes in high selector
// - clear input selectors before rate change
// - wait 125 us before rate write
// - each upsample path has own enable
// - each downsample path has own enable
// - refuse enable when clock budget short
// - refusal leaves running paths untouched
// - status shows which paths really run
// - input source runs at matching rate
// - enables stay zero without system clock
// - selectors zero until system clock runs
// - high rate field bits 14:11, reset 0
// - low rate field bits 14:11, reset 0
// - rates between 8 and 192 kHz
// - both rates in one clock domain
// - clear downsample or upsample selectors accordingly
// - bits 15,14 enable upsample paths
// - bits 9,8 enable downsample paths
// - this instance carries two paths each way
// - integer ratios up to 24
module irc_dev (
	// clock and reset
	input  wire logic                                          mclk_i,
	input  wire logic                                          rstn_i,

	// register side
	irc_if.dev                                                 bus,

	// processing cycles available per high-rate sample
	input  wire logic [irc_pkg::BUD_W-1:0]                     sys_budget_i,
	input  wire logic [irc_pkg::BUD_W-1:0]                     async_budget_i,

	// rate strobes
	input  wire logic                                          lo_stb_i,
	input  wire logic                                          hi_stb_i,

	// samples in: 0,1 upsample, 2,3 downsample
	input  wire logic [irc_pkg::NPATH-1:0][irc_pkg::SMP_W-1:0] smp_i,

	// samples out
	output logic [irc_pkg::NPATH-1:0]                          smp_vld_o,
	output logic [irc_pkg::NPATH-1:0][irc_pkg::SMP_W-1:0]      smp_o
);
	// ----------
	// state
	// ----------
	typedef struct packed {
		logic [3:0]                hi_rate;
		logic [3:0]                lo_rate;
		logic [irc_pkg::NPATH-1:0] req;
		logic [irc_pkg::NPATH-1:0] active;
		logic                      underclock;
	} irc_dev_st_t;

	irc_dev_st_t               s;
	irc_dev_st_t               next_s;
	logic [irc_pkg::NPATH-1:0] req_v;
	logic [irc_pkg::NPATH-1:0] grant;
	logic [2:0]                used;
	logic                      refused;
	logic                      cfg_ok;
	logic [irc_pkg::BUD_W-1:0] avail;

	// ----------
	// helpers
	// ----------

	// number of running paths
	function automatic logic [2:0] count(input logic [irc_pkg::NPATH-1:0] p);
		logic [2:0] n;
		n = 3'h0;

		for (int i = 0; i < irc_pkg::NPATH; i++) begin
			n = n + 3'(p[i]);
		end
		return n;
	endfunction

	// one more path fits in the budget
	function automatic logic fits(input logic [2:0] n, input logic [irc_pkg::BUD_W-1:0] b);
		logic [31:0] need;

		need = (32'(n) + 32'h0000_0001) * 32'(irc_pkg::PATH_COST);
		return need <= 32'(b);
	endfunction

	// ----------
	// governing clock and its budget
	// ----------
	always_comb begin
		// both codes defined and in one domain, else nothing may start
		cfg_ok = irc_pkg::code_ok(s.hi_rate) && irc_pkg::code_ok(s.lo_rate) &&
			(s.hi_rate[irc_pkg::ASYNC_BIT] == s.lo_rate[irc_pkg::ASYNC_BIT]);

		// governing domain budget
		avail = s.hi_rate[irc_pkg::ASYNC_BIT] ? async_budget_i : sys_budget_i;
	end

	// ----------
	// register writes and enable arbitration
	// ----------
	always_comb begin
		next_s  = s;
		req_v   = irc_pkg::en_bits(bus.reg_wdata);
		grant   = s.active;
		used    = count(s.active);
		refused = 1'b0;

		// one register per write strobe
		if (bus.reg_wr) begin
			case (bus.reg_idx)
				irc_pkg::HI_RATE_IDX: begin
					next_s.hi_rate = bus.reg_wdata[irc_pkg::RATE_LSB +: irc_pkg::RATE_W];
				end
				irc_pkg::LO_RATE_IDX: begin
					next_s.lo_rate = bus.reg_wdata[irc_pkg::RATE_LSB +: irc_pkg::RATE_W];
				end
				irc_pkg::PATH_EN_IDX: begin
					next_s.req = req_v;
					// cleared bits stop their own path only
					for (int i = 0; i < irc_pkg::NPATH; i++) begin
						if (!req_v[i]) begin
							grant[i] = 1'b0;
						end
					end

					// budget spent by kept paths
					used = count(grant);

					// new requests in path order, each checked against what is left
					for (int i = 0; i < irc_pkg::NPATH; i++) begin
						if (req_v[i] && !s.active[i]) begin
							if (cfg_ok && fits(used, avail)) begin
								grant[i] = 1'b1;
								used     = used + 3'h1;
							end else begin
								refused = 1'b1;
							end
						end
					end

					// requested running paths stay
					next_s.active     = grant;
					// flag reflects this write only
					next_s.underclock = refused;
				end
				default: begin
					next_s = s;
				end
			endcase
		end
	end

	// ----------
	// state register
	// ----------
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			// rate codes to zero, all paths off
			s.hi_rate    <= irc_pkg::RATE_RST;
			s.lo_rate    <= irc_pkg::RATE_RST;
			s.req        <= '0;
			s.active     <= '0;
			s.underclock <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// ----------
	// status back to the controller
	// ----------
	assign bus.path_active = s.active;
	assign bus.underclock  = s.underclock;

	// ----------
	// paths: two upsample from low rate, two downsample from high rate
	// ----------
	for (genvar g = 0; g < irc_pkg::NPATH; g++) begin : g_path
		// half up, half down
		localparam bit UP = (g < irc_pkg::NPATH / 2);
		logic in_stb;
		logic out_stb;

		// strobes by direction
		assign in_stb  = UP ? lo_stb_i : hi_stb_i;
		assign out_stb = UP ? hi_stb_i : lo_stb_i;

		// one path
		irc_path u_path (
			.mclk_i    (mclk_i),
			.rstn_i    (rstn_i),
			.en_i      (s.active[g]),
			.in_stb_i  (in_stb),
			.in_smp_i  (smp_i[g]),
			.out_stb_i (out_stb),
			.out_vld_o (smp_vld_o[g]),
			.out_smp_o (smp_o[g])
		);
	end
endmodule
`default_nettype wire

// *** testbench/irc_assertions.sv ***
// assertions on the register link between controller and device
`timescale 1ns/1ps
`default_nettype none
module irc_assertions (
	// clock and reset
	input wire logic        mclk_i,
	input wire logic        rstn_i,
	// link signals
	input wire logic        reg_wr,
	input wire logic [11:0] reg_idx,
	input wire logic [15:0] reg_wdata,
	input wire logic [3:0]  path_active,
	input wire logic        underclock
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	// enable write and its request vector
	logic       en_wr;
	logic [3:0] req;
	assign en_wr = reg_wr && (reg_idx == 12'h0efb);
	assign req   = {reg_wdata[8], reg_wdata[9], reg_wdata[14], reg_wdata[15]};
	// device end
	a_keep_run: assert property (en_wr |=> ($past(path_active & req) & ~path_active) == 4'h0)
		else $error("running path stopped");
	a_grant_subset: assert property (en_wr |=> (path_active & ~$past(req)) == 4'h0)
		else $error("path runs unrequested");
	a_uclk_refused: assert property (en_wr |=> underclock == |($past(req) & ~path_active))
		else $error("underclock flag wrong");
	a_state_hold: assert property (!en_wr |=> $stable(path_active) && $stable(underclock))
		else $error("path state moved without write");
	// controller end
	a_idx_known: assert property (reg_wr |-> reg_idx inside {12'h0ef9, 12'h0efa, 12'h0efb})
		else $error("write to unknown index");
	a_rate_pair: assert property (reg_wr && reg_idx == 12'h0ef9 |=> reg_wr && reg_idx == 12'h0efa)
		else $error("high rate not followed by low rate");
	a_rate_field: assert property (reg_wr && reg_idx != 12'h0efb |->
		(reg_wdata & 16'h87ff) == 16'h0000 && reg_wdata[14:11] inside {4'h0, 4'h1, 4'h2, 4'h8, 4'h9})
		else $error("bad rate word");
	a_same_domain: assert property (reg_wr && reg_idx == 12'h0efa |-> reg_wdata[14] == $past(reg_wdata[14]))
		else $error("rates in two domains");
	a_en_field: assert property (en_wr |-> (reg_wdata & 16'h3cff) == 16'h0000)
		else $error("stray enable bits");
endmodule
`default_nettype wire

// *** testbench/isochronous_rate_converter_tb.sv ***
// self-checking bench: controller and device joined over the register link
`timescale 1ns/1ps
`default_nettype none
module isochronous_rate_converter_tb;
	// ----------
	// signals and model state
	// ----------
	localparam int SETTLE = 8;
	logic             mclk_i = 1'b0;
	logic             rstn_i = 1'b0;
	logic [31:0]      s_axi_awaddr_i = 32'h0000_0000;
	logic [31:0]      s_axi_wdata_i = 32'h0000_0000;
	logic [31:0]      s_axi_araddr_i = 32'h0000_0000;
	logic [3:0]       s_axi_wstrb_i = 4'hf;
	logic             s_axi_awvalid_i = 1'b0;
	logic             s_axi_wvalid_i = 1'b0;
	logic             s_axi_bready_i = 1'b0;
	logic             s_axi_arvalid_i = 1'b0;
	logic             s_axi_rready_i = 1'b0;
	logic             system_audio_clock_en_i = 1'b0;
	logic             lo_stb_i = 1'b0;
	logic             hi_stb_i = 1'b0;
	logic [15:0]      sys_budget_i = 16'h0000;
	logic [15:0]      async_budget_i = 16'h0040;
	logic [3:0][23:0] smp_i = '0;
	logic             s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0]       s_axi_bresp_o, s_axi_rresp_o, r;
	logic [31:0]      s_axi_rdata_o, input_source_select_o, d;
	logic [3:0]       smp_vld_o, req, run = 4'h0, last = 4'h0;
	logic [3:0][23:0] smp_o;
	logic [23:0]      hs [4] = '{default: 24'h00_0000};
	logic [31:0]      bad_rate [3] = '{32'h0000_0080, 32'h0000_0003, 32'h0000_0002};
	logic             uc = 1'b0;
	int               checked = 0, bad_count = 0, seed = 32'h3d20, bud, n;
	// the two ends and the link checker
	irc_if bus ();
	irc_host #(.SETTLE_CYCLES(SETTLE)) irc_host_i (.mclk_i, .rstn_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
		.s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
		.s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
		.s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .system_audio_clock_en_i, .input_source_select_o, .bus);
	irc_dev irc_dev_i (.mclk_i, .rstn_i, .bus, .sys_budget_i, .async_budget_i, .lo_stb_i, .hi_stb_i, .smp_i,
		.smp_vld_o, .smp_o);
	irc_assertions irc_assertions_i (.mclk_i, .rstn_i, .reg_wr(bus.reg_wr), .reg_idx(bus.reg_idx),
		.reg_wdata(bus.reg_wdata), .path_active(bus.path_active), .underclock(bus.underclock));
	// ----------
	// tasks and model
	// ----------
	// compare and count
	task automatic chk(input logic [33:0] got, input logic [33:0] want);
		checked++;
		if (got !== want) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask
	// one write, address and data offered together
	task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] q);
		@(posedge mclk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= v;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do begin
			@(posedge mclk_i);
			if (s_axi_awready_o === 1'b1)
				s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o === 1'b1)
				s_axi_wvalid_i <= 1'b0;
		end while (s_axi_bvalid_o !== 1'b1);
		q = s_axi_bresp_o;
		s_axi_bready_i <= 1'b0;
	endtask
	// one read
	task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] q);
		@(posedge mclk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do begin
			@(posedge mclk_i);
			if (s_axi_arready_o === 1'b1)
				s_axi_arvalid_i <= 1'b0;
		end while (s_axi_rvalid_o !== 1'b1);
		v = s_axi_rdata_o;
		q = s_axi_rresp_o;
		s_axi_rready_i <= 1'b0;
	endtask
	// read and compare with an okay answer
	task automatic rc(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0]  q;
		rd(a, v, q);
		chk({q, v}, {irc_pkg::RESP_OKAY, e});
	endtask
	// kept paths stay, new ones granted in order while budget lasts
	function automatic logic [3:0] grant(input logic [3:0] rq, input logic [3:0] rn, input int b);
		logic [3:0] g;
		int         k;
		g = rq & rn;
		k = $countones(g);
		for (int i = 0; i < 4; i++) begin
			if (rq[i] && !g[i] && (k + 1) * 16 <= b) begin
				g[i] = 1'b1;
				k++;
			end
		end
		return g;
	endfunction
	// low-rate strobe then high-rate strobe with fresh samples
	task automatic smp_round();
		@(posedge mclk_i);
		for (int i = 0; i < 4; i++) begin
			hs[i] = run[i] ? hs[i] : 24'h00_0000;
			smp_i[i] <= 24'($random(seed));
		end
		lo_stb_i <= 1'b1;
		@(posedge mclk_i);
		lo_stb_i <= 1'b0;
		hi_stb_i <= 1'b1;
		for (int i = 0; i < 2; i++)
			hs[i] = run[i] ? smp_i[i] : 24'h00_0000;
		@(posedge mclk_i);
		hi_stb_i <= 1'b0;
		chk(34'(smp_vld_o), 34'(run & 4'hc));
		for (int i = 2; i < 4; i++) begin
			if (run[i])
				chk(34'(smp_o[i]), 34'(hs[i]));
			hs[i] = run[i] ? smp_i[i] : 24'h00_0000;
		end
		@(posedge mclk_i);
		chk(34'(smp_vld_o), 34'(run & 4'h3));
		for (int i = 0; i < 2; i++)
			if (run[i])
				chk(34'(smp_o[i]), 34'(hs[i]));
	endtask
	// counts and verdict
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----------
	// clock, watchdog and tests
	// ----------
	// 200 MHz clock
	initial forever #2.5 mclk_i = ~mclk_i;
	// hang guard
	initial begin
		repeat (20000) @(posedge mclk_i);
		bad_count++;
		print_verdict();
	end
	// main sequence
	initial begin
		repeat (3) @(posedge mclk_i);
		rstn_i <= 1'b1;
		rc(irc_pkg::A_RATES, 32'h0000_0000);
		rc(irc_pkg::A_STAT, 32'h0000_0000);
		wr(32'h0000_0040, 32'h0000_0001, r);
		chk(34'(r), 34'(irc_pkg::RESP_SLVERR));
		rd(32'h0000_0040, d, r);
		chk({r, d}, {irc_pkg::RESP_SLVERR, 32'h0000_0000});
		$display("test reset and map done");
		// mixed domains, reserved code, inverted order
		foreach (bad_rate[i]) begin
			wr(irc_pkg::A_RATES, bad_rate[i], r);
			rc(irc_pkg::A_STAT, 32'h0000_0040);
			wr(irc_pkg::A_STAT, 32'h0000_0040, r);
		end
		rc(irc_pkg::A_RATES, 32'h0000_0000);
		$display("test bad rates done");
		// selectors held at zero until the audio clock runs
		wr(irc_pkg::A_SRC, 32'h0403_0201, r);
		repeat (2) @(posedge mclk_i);
		chk(34'(input_source_select_o), 34'h0);
		system_audio_clock_en_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		chk(34'(input_source_select_o), 34'h0_0403_0201);
		// low rate change: upsample selectors cleared, wait, both writes
		wr(irc_pkg::A_RATES, 32'h0000_0010, r);
		chk(34'(input_source_select_o), 34'h0_0403_0000);
		n = 0;
		while (bus.reg_wr !== 1'b1 && n < 100) begin
			@(posedge mclk_i);
			n++;
		end
		chk(34'(n >= SETTLE), 34'h1);
		chk(34'({bus.reg_idx, bus.reg_wdata}), {6'h00, irc_pkg::HI_RATE_IDX, 16'h0000});
		@(posedge mclk_i);
		chk(34'({bus.reg_idx, bus.reg_wdata}), {6'h00, irc_pkg::LO_RATE_IDX, 16'h0800});
		rc(irc_pkg::A_RATES, 32'h0000_0010);
		chk(34'(input_source_select_o), 34'h0_0403_0201);
		$display("test rate change done");
		// random enables against a random budget, then samples
		for (int k = 0; k < 12; k++) begin
			if (k == 6)
				wr(irc_pkg::A_RATES, 32'h0000_0098, r);
			req = 4'($random(seed));
			bud = 16 * (($random(seed) & 3) + 1);
			sys_budget_i <= 16'(k < 6 ? bud : 0);
			async_budget_i <= 16'(k < 6 ? 0 : bud);
			wr(irc_pkg::A_PATH, 32'(req), r);
			if (req != last) begin
				run = grant(req, run, bud);
				uc = |(req & ~run);
			end
			last = req;
			repeat (2) @(posedge mclk_i);
			rc(irc_pkg::A_STAT, {27'h000_0000, uc, run});
			smp_round();
		end
		$display("test enables done");
		// audio clock off stops paths and clears selectors
		system_audio_clock_en_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		chk(34'(bus.path_active), 34'h0);
		rc(irc_pkg::A_RATES, 32'h0000_0098);
		chk(34'(input_source_select_o), 34'h0);
		$display("test clock off done");
		print_verdict();
	end
endmodule
`default_nettype wire
